//--- hdl/step_motion_defs.svh
// Named constants for the motion parameter and homing block.
// Assumes a 25 MHz system clock; included by the settling timer and the motion module, not by the package or the interface.
`ifndef STEP_MOTION_DEFS_SVH
`define STEP_MOTION_DEFS_SVH

`define CLK_HZ              25000000
`define HOLD_UNIT_MS        10
`define HOLD_TICK_CYCLES    (`CLK_HZ / 1000 * `HOLD_UNIT_MS)

`define JOG_SPEED_DEFAULT   16'h0190
`define JOG_SPEED_MAX       16'h6d60
`define DIVIDER_DEFAULT     8'h04
`define DIVIDER_MIN         16'h0001
`define DIVIDER_MAX         16'h00ff
`define HOLD_DEFAULT        8'h64
`define HOLD_MIN            16'h0005
`define HOLD_MAX            16'h00ff
`define HOLD_DISABLE        8'hff
`define HOME_DIR_DEFAULT    1'h0

`define MEM_OPT_PARAMS      16'h0000
`define MEM_OPT_PROGRAM     16'h0001
`define MEM_OPT_DEFAULTS    16'h0002
`define MEM_OPT_ERASE       16'h0003

`endif

//--- hdl/step_motion_pkg.sv
// Types shared by the motion parameter and homing block.
// Assumes the command parser decodes each command letter into cmd_code_type.
package step_motion_pkg;

   typedef enum logic [2:0] {
      CMD_JOG_SPEED,
      CMD_MEMORY,
      CMD_DIVIDER,
      CMD_HOLD,
      CMD_HOME
   } cmd_code_type;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_JOG,
      ST_JOG_STOP,
      ST_HOME_SEEK,
      ST_HOME_DECEL,
      ST_HOME_BACK
   } motion_state_type;

endpackage

//--- hdl/hold_timer_if.sv
// Carrier between the motion block and its hold-settling timer.
// Assumes both ends share mclk_i.
`timescale 1ns/10ps
interface hold_timer_if;
   logic       step;
   logic       last_step;
   logic [7:0] delay;
   logic       run_current;

   modport owner (output step, output last_step, output delay, input run_current);
   modport timer (input step, input last_step, input delay, output run_current);
endinterface

//--- hdl/hold_settle_timer.sv
// Hold-settling timer: drops winding drive from run to hold after motion ends.
// Assumes step pulses are one clock wide and synchronous to mclk_i.
`timescale 1ns/10ps
`include "step_motion_defs.svh"
module hold_settle_timer #(
   parameter int TICK_CYCLES = `HOLD_TICK_CYCLES
) (
   input  wire logic   mclk_i,
   input  wire logic   arst_n_i,
   hold_timer_if.timer t
);
   logic [17:0] prescale;
   logic [7:0]  ticks;
   logic        counting;
   logic        run;
   wire         tick     = counting && (prescale == 18'(TICK_CYCLES - 1));
   // R15: 255 disables drop
   wire         disabled = (t.delay == `HOLD_DISABLE);
   wire         expire   = tick && !disabled && (8'(ticks + 8'h01) >= t.delay);

   assign t.run_current = run;

   // R24: 10 ms tick
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prescale <= 18'h00000;
         ticks    <= 8'h00;
      end else if (t.step || !counting || tick) begin
         prescale <= 18'h00000;
         ticks    <= (t.step || !counting) ? 8'h00 : 8'(ticks + 8'h01);
      end else begin
         prescale <= 18'(prescale + 18'h00001);
      end
   end

   // R14: restart on step
   // R13: drop to hold
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         counting <= 1'b0;
         run      <= 1'b0;
      end else if (t.step) begin
         counting <= t.last_step;
         run      <= 1'b1;
      end else if (expire) begin
         counting <= 1'b0;
         run      <= 1'b0;
      end
   end

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!arst_n_i);

   hold_drop_a: assert property ($fell(run) |-> $past(tick) && $past(ticks) + 8'h01 >= $past(t.delay)) // R13
      else $error("Hold current applied before the settling delay ran out.");
   hold_never_a: assert property (counting && disabled && !t.step |=> run) // R15
      else $error("Run current dropped while the delay was set to disable.");
   step_restart_a: assert property (t.step |=> run && ticks == 8'h00 && counting == $past(t.last_step)) // R14
      else $error("A step did not restart the settling countdown.");
endmodule

//--- hdl/step_motion_param_homing.sv
// Motion parameters (jog speed, speed divider, hold delay), memory clear and restore,
// jog inputs and the three-stage (seek, decelerate, reverse) find-home sequence of a step motor controller.
// Assumes a command parser delivering decoded commands and a ramp generator that
// takes the run, direction, ramp, stop and rate outputs and reports steps back.
// How it works
// R1: Jog speed is kept in steps per second, default 400, used while jogging.
// R2: Jog speed query without value in immediate mode replies the stored speed.
// R3: A new jog press aborts the running program and halts any motion.
// R4: Memory option 0 reloads parameters from non-volatile copies only.
// R5: Memory option 1 reloads program memory from non-volatile copies only.
// R6: Memory option 2 loads factory default parameters only.
// R7: Memory option 3 erases working program space only.
// R8: No memory option ever writes the non-volatile store.
// R9: Memory command without option acts as option 0.
// R10: Every ramp and slew rate is divided by the divider, 1 to 255, default 4.
// R11: Divider write acts at once; query without value replies the divider.
// R12: The host leaves the divider alone while the axis moves.
// R13: After motion, drive drops to hold once the 10 ms delay, default 100, ends.
// R14: Countdown starts at the final step and restarts on any further step.
// R15: A delay of 255 keeps run current forever.
// R16: Delay writes below 5 or above 255 store the default 100 instead.
// R17: Delay write acts at once; query without value replies the delay.
// R18: Find-home takes a speed and optional direction, positive when absent.
// R19: Homing ramps up to the home speed and runs until the switch is active.
// R20: On switch active, decelerate to stop, then reverse at initial velocity.
// R21: Stop the reverse move the moment the switch turns inactive.
// R22: Parameter writes touch working copies only; saving is a separate command.
// R23: The home switch pin is inverted, low reads as active.
// R24: The hold countdown runs on a 10 ms tick derived from the system clock.
`timescale 1ns/10ps
`include "step_motion_defs.svh"
module step_motion_param_homing #(
   parameter int TICK_CYCLES = `HOLD_TICK_CYCLES
) (
   input  wire logic                        mclk_i,
   input  wire logic                        arst_n_i,
   input  wire logic                        cmd_valid_i,
   input  wire step_motion_pkg::cmd_code_type cmd_code_i,
   input  wire logic                        cmd_has_value_i,
   input  wire logic [15:0]                 cmd_value_i,
   input  wire logic                        cmd_arg2_present_i,
   input  wire logic                        cmd_arg2_i,
   input  wire logic                        immediate_mode_i,
   output logic                             reply_valid_o,
   output logic [15:0]                      reply_value_o,
   input  wire logic [15:0]                 nv_jog_speed_i,
   input  wire logic [7:0]                  nv_divider_i,
   input  wire logic [7:0]                  nv_hold_delay_i,
   output logic                             mem_restore_params_o,
   output logic                             mem_restore_program_o,
   output logic                             mem_load_defaults_o,
   output logic                             mem_erase_program_o,
   input  wire logic                        jog_plus_i,
   input  wire logic                        jog_minus_i,
   output logic                             abort_program_o,
   output logic                             halt_motion_o,
   input  wire logic                        home_sw_n_i,
   input  wire logic [15:0]                 initial_velocity_i,
   input  wire logic                        motor_stopped_i,
   input  wire logic                        step_pulse_i,
   input  wire logic                        last_step_i,
   output logic                             move_run_o,
   output logic                             move_dir_o,
   output logic                             move_ramp_o,
   output logic                             move_stop_o,
   output logic [15:0]                      move_rate_o,
   output logic                             home_busy_o,
   output logic [7:0]                       divider_o,
   output logic                             run_current_o
);
   step_motion_pkg::motion_state_type state;
   step_motion_pkg::motion_state_type next_state;
   logic [15:0] jog_speed;
   logic [7:0]  divider;
   logic [7:0]  hold_delay;
   logic [15:0] home_speed;
   logic        jog_prev;
   hold_timer_if ht ();

   // Divides a requested step rate by the prescaler; a zero divider passes it through.
   function automatic logic [15:0] scale_rate(input logic [15:0] rate, input logic [7:0] div);
      scale_rate = (div == 8'h00) ? rate : 16'(rate / {8'h00, div});
   endfunction

   wire         has_val    = cmd_has_value_i;
   wire         query      = cmd_valid_i && !has_val && immediate_mode_i;
   wire         cmd_jog    = cmd_valid_i && (cmd_code_i == step_motion_pkg::CMD_JOG_SPEED);
   wire         cmd_mem    = cmd_valid_i && (cmd_code_i == step_motion_pkg::CMD_MEMORY);
   wire         cmd_div    = cmd_valid_i && (cmd_code_i == step_motion_pkg::CMD_DIVIDER);
   wire         cmd_hold   = cmd_valid_i && (cmd_code_i == step_motion_pkg::CMD_HOLD);
   wire         cmd_home   = cmd_valid_i && (cmd_code_i == step_motion_pkg::CMD_HOME);
   wire         jog_write  = cmd_jog && has_val && (cmd_value_i <= `JOG_SPEED_MAX);
   wire         div_write  = cmd_div && has_val && (cmd_value_i >= `DIVIDER_MIN)
                             && (cmd_value_i <= `DIVIDER_MAX);
   wire         hold_write = cmd_hold && has_val;
   wire         hold_ok    = (cmd_value_i >= `HOLD_MIN) && (cmd_value_i <= `HOLD_MAX);
   // R9: missing option means 0
   wire  [15:0] mem_opt    = has_val ? cmd_value_i : `MEM_OPT_PARAMS;
   wire         mem_params = cmd_mem && (mem_opt == `MEM_OPT_PARAMS);
   wire         mem_dflt   = cmd_mem && (mem_opt == `MEM_OPT_DEFAULTS);
   // R23: switch input inverted
   wire         home_active = !home_sw_n_i;
   wire         jog_level  = jog_plus_i || jog_minus_i;
   wire         jog_hit    = jog_level && !jog_prev;
   wire         home_start = cmd_home && has_val && (cmd_value_i != 16'h0000)
                             && (state == step_motion_pkg::ST_IDLE) && !jog_hit;
   // R18: default direction
   wire         home_dir   = cmd_arg2_present_i ? cmd_arg2_i : `HOME_DIR_DEFAULT;
   wire  [15:0] sel_rate   = (state == step_motion_pkg::ST_HOME_BACK) ? initial_velocity_i :
                             (state == step_motion_pkg::ST_HOME_SEEK ||
                              state == step_motion_pkg::ST_HOME_DECEL) ? home_speed : jog_speed;

   assign move_run_o  = (state != step_motion_pkg::ST_IDLE);
   assign move_ramp_o = (state != step_motion_pkg::ST_HOME_BACK);
   assign move_stop_o = (state == step_motion_pkg::ST_JOG_STOP) ||
                        (state == step_motion_pkg::ST_HOME_DECEL);
   assign home_busy_o = (state == step_motion_pkg::ST_HOME_SEEK) ||
                        (state == step_motion_pkg::ST_HOME_DECEL) ||
                        (state == step_motion_pkg::ST_HOME_BACK);
   assign divider_o   = divider;

   // R19: seek until switch active
   // R20: decelerate, then reverse
   // R21: stop on switch release
   always_comb begin
      next_state = state;
      case (state)
         step_motion_pkg::ST_IDLE:       if (home_start) next_state = step_motion_pkg::ST_HOME_SEEK;
         step_motion_pkg::ST_JOG:        if (!jog_level) next_state = step_motion_pkg::ST_JOG_STOP;
         step_motion_pkg::ST_JOG_STOP:   if (motor_stopped_i) next_state = step_motion_pkg::ST_IDLE;
         step_motion_pkg::ST_HOME_SEEK:  if (home_active) next_state = step_motion_pkg::ST_HOME_DECEL;
         step_motion_pkg::ST_HOME_DECEL: if (motor_stopped_i) next_state = step_motion_pkg::ST_HOME_BACK;
         step_motion_pkg::ST_HOME_BACK:  if (!home_active) next_state = step_motion_pkg::ST_IDLE;
         default:                        next_state = step_motion_pkg::ST_IDLE;
      endcase
      // R3: jog overrides everything
      if (jog_hit) begin
         next_state = step_motion_pkg::ST_JOG;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state    <= step_motion_pkg::ST_IDLE;
         jog_prev <= 1'b0;
      end else begin
         state    <= next_state;
         jog_prev <= jog_level;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         move_dir_o <= `HOME_DIR_DEFAULT;
         home_speed <= 16'h0000;
      end else if (jog_hit) begin
         move_dir_o <= jog_minus_i;
      end else if (home_start) begin
         move_dir_o <= home_dir;
         home_speed <= cmd_value_i;
      end else if (state == step_motion_pkg::ST_HOME_DECEL && motor_stopped_i) begin
         move_dir_o <= !move_dir_o;
      end
   end

   // R10: rate divided by prescaler
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         move_rate_o <= 16'h0000;
      end else begin
         move_rate_o <= scale_rate(sel_rate, divider);
      end
   end

   // R3: abort and halt pulses
   // R21: halt at switch release
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         abort_program_o <= 1'b0;
         halt_motion_o   <= 1'b0;
      end else begin
         abort_program_o <= jog_hit;
         halt_motion_o   <= jog_hit || (state == step_motion_pkg::ST_HOME_BACK && !home_active);
      end
   end

   // R4: reload parameters
   // R5: reload program
   // R6: factory defaults
   // R7: erase program
   // R8: no store write
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mem_restore_params_o  <= 1'b0;
         mem_restore_program_o <= 1'b0;
         mem_load_defaults_o   <= 1'b0;
         mem_erase_program_o   <= 1'b0;
      end else begin
         mem_restore_params_o  <= mem_params;
         mem_restore_program_o <= cmd_mem && (mem_opt == `MEM_OPT_PROGRAM);
         mem_load_defaults_o   <= mem_dflt;
         mem_erase_program_o   <= cmd_mem && (mem_opt == `MEM_OPT_ERASE);
      end
   end

   // R22: working copies only
   // R1: jog speed register
   // R11: divider takes effect at once
   // R16: reject bad delay
   // R17: delay takes effect at once
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         jog_speed  <= `JOG_SPEED_DEFAULT;
         divider    <= `DIVIDER_DEFAULT;
         hold_delay <= `HOLD_DEFAULT;
      end else if (mem_dflt) begin
         jog_speed  <= `JOG_SPEED_DEFAULT;
         divider    <= `DIVIDER_DEFAULT;
         hold_delay <= `HOLD_DEFAULT;
      end else if (mem_params) begin
         jog_speed  <= nv_jog_speed_i;
         divider    <= nv_divider_i;
         hold_delay <= nv_hold_delay_i;
      end else begin
         if (jog_write) jog_speed <= cmd_value_i;
         if (div_write) divider <= cmd_value_i[7:0];
         if (hold_write) hold_delay <= hold_ok ? cmd_value_i[7:0] : `HOLD_DEFAULT;
      end
   end

   // R2: jog speed query
   // R11: divider query
   // R17: delay query
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reply_valid_o <= 1'b0;
         reply_value_o <= 16'h0000;
      end else begin
         reply_valid_o <= query && (cmd_jog || cmd_div || cmd_hold);
         if (query && cmd_jog) reply_value_o <= jog_speed;
         else if (query && cmd_div) reply_value_o <= {8'h00, divider};
         else if (query && cmd_hold) reply_value_o <= {8'h00, hold_delay};
      end
   end

   // R13: hold settling timer
   // R14: step restarts timer
   assign ht.step      = step_pulse_i;
   assign ht.last_step = last_step_i;
   assign ht.delay     = hold_delay;
   assign run_current_o = ht.run_current;

   hold_settle_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_hold (
      .mclk_i   (mclk_i),
      .arst_n_i (arst_n_i),
      .t        (ht.timer)
   );

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!arst_n_i);

   sequence back_release;
      state == step_motion_pkg::ST_HOME_BACK && !home_active && !jog_hit;
   endsequence
   sequence seek_hit;
      state == step_motion_pkg::ST_HOME_SEEK && home_active && !jog_hit;
   endsequence

   jog_abort_a: assert property (jog_hit |=> abort_program_o && halt_motion_o && move_run_o) // R3
      else $error("Jog press did not abort the program and halt motion.");
   jog_rate_a: assert property (state == step_motion_pkg::ST_JOG && $past(state) ==
                  step_motion_pkg::ST_JOG && $stable(jog_speed) && $stable(divider)
                  |-> move_rate_o == scale_rate(jog_speed, divider)) // R10
      else $error("Jog rate is not the jog speed over the divider.");
   jog_query_a: assert property (query && cmd_jog |=> reply_valid_o &&
                  reply_value_o == $past(jog_speed) && jog_speed == $past(jog_speed)) // R2
      else $error("Jog speed query did not reply the stored value.");
   div_write_a: assert property (div_write && !mem_dflt && !mem_params
                  |=> divider_o == $past(cmd_value_i[7:0])) // R11
      else $error("Divider write did not take effect at once.");
   hold_reject_a: assert property (hold_write && !hold_ok && !mem_dflt && !mem_params
                  |=> hold_delay == `HOLD_DEFAULT) // R16
      else $error("Invalid hold delay was not replaced by the default.");
   mem_noopt_a: assert property (cmd_mem && !has_val |=> mem_restore_params_o
                  && !mem_restore_program_o && !mem_erase_program_o) // R9
      else $error("Memory command without option did not restore parameters.");
   home_dir_a: assert property (home_start && !cmd_arg2_present_i
                  |=> state == step_motion_pkg::ST_HOME_SEEK && !move_dir_o && move_ramp_o) // R18
      else $error("Homing without direction did not start positive.");
   seek_decel_a: assert property (seek_hit |=> move_stop_o ##0 move_run_o) // R20
      else $error("Switch activation did not start the deceleration.");
   home_stop_a: assert property (back_release |=> halt_motion_o &&
                  state == step_motion_pkg::ST_IDLE && !move_run_o) // R21
      else $error("Reverse homing did not stop at switch release.");
endmodule

//--- tb/motor_axis_model.sv
// Behavioural ramp generator and motor at the far side of the motion outputs.
// Assumes the motion block's run and stop levels on mclk_i; steps every STEP_GAP cycles.
`timescale 1ns/10ps
module motor_axis_model #(
   parameter int STEP_GAP = 4
) (
   input  wire logic mclk_i,
   input  wire logic arst_n_i,
   input  wire logic move_run_i,
   input  wire logic move_stop_i,
   output logic      motor_stopped_o,
   output logic      step_pulse_o,
   output logic      last_step_o
);
   logic [3:0] gap;

   // A stop request ends with one flagged final step, and the axis reports rest on the same clock.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         gap <= 4'h0;
         motor_stopped_o <= 1'b1;
         step_pulse_o <= 1'b0;
         last_step_o <= 1'b0;
      end else begin
         step_pulse_o <= 1'b0;
         last_step_o <= 1'b0;
         if (move_run_i && !move_stop_i) begin
            motor_stopped_o <= 1'b0;
            gap <= (gap == 4'(STEP_GAP - 1)) ? 4'h0 : gap + 4'h1;
            step_pulse_o <= (gap == 4'(STEP_GAP - 1));
         end else if (move_run_i && !motor_stopped_o) begin
            gap <= (gap == 4'(STEP_GAP - 1)) ? 4'h0 : gap + 4'h1;
            if (gap == 4'(STEP_GAP - 1)) begin
               step_pulse_o <= 1'b1;
               last_step_o <= 1'b1;
               motor_stopped_o <= 1'b1;
            end
         end else if (!move_run_i) begin
            motor_stopped_o <= 1'b1;
         end
      end
   end
endmodule

//--- tb/step_motion_param_homing_tb.sv
// Self-checking bench for the motion parameter and homing block.
// Assumes the design's hold tick shortened to 4 cycles and the axis model above.
`timescale 1ns/10ps
module step_motion_param_homing_tb;
   logic mclk_i = 0, arst_n_i = 0, cmd_valid = 0, has = 0, jog_p = 0, jog_m = 0, sw_n = 1;
   logic a2p = 0, a2 = 0, imm = 1, stopped, step, last, rv, rst_par, rst_prg, ld_def, erase;
   logic abort, halt, run, dir, ramp, stop, busy, run_cur;
   logic [15:0] value = 16'h0000, init_vel = 16'h0000, rval, rate;
   logic [7:0]  div;
   logic [7:0]  exp_div [4] = '{8'h07, 8'h07, 8'h04, 8'h04};
   step_motion_pkg::cmd_code_type code = step_motion_pkg::CMD_HOLD;
   int err_count = 0;
   int num_checks = 0;

   always #20 mclk_i = ~mclk_i;

   step_motion_param_homing #(.TICK_CYCLES(4)) u_step_motion_param_homing (
      .mclk_i(mclk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid), .cmd_code_i(code),
      .cmd_has_value_i(has), .cmd_value_i(value), .cmd_arg2_present_i(a2p), .cmd_arg2_i(a2),
      .immediate_mode_i(imm), .reply_valid_o(rv), .reply_value_o(rval),
      .nv_jog_speed_i(16'h03e8), .nv_divider_i(8'h07), .nv_hold_delay_i(8'h32),
      .mem_restore_params_o(rst_par), .mem_restore_program_o(rst_prg),
      .mem_load_defaults_o(ld_def), .mem_erase_program_o(erase), .jog_plus_i(jog_p),
      .jog_minus_i(jog_m), .abort_program_o(abort), .halt_motion_o(halt), .home_sw_n_i(sw_n),
      .initial_velocity_i(init_vel), .motor_stopped_i(stopped), .step_pulse_i(step),
      .last_step_i(last), .move_run_o(run), .move_dir_o(dir), .move_ramp_o(ramp),
      .move_stop_o(stop), .move_rate_o(rate), .home_busy_o(busy), .divider_o(div),
      .run_current_o(run_cur));

   motor_axis_model #(.STEP_GAP(4)) u_motor_axis_model (
      .mclk_i(mclk_i), .arst_n_i(arst_n_i), .move_run_i(run), .move_stop_i(stop),
      .motor_stopped_o(stopped), .step_pulse_o(step), .last_step_o(last));

   task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask

   task summarize;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task send(input step_motion_pkg::cmd_code_type c, input logic h, input logic [15:0] v);
      @(posedge mclk_i);
      code <= c;
      has <= h;
      value <= v;
      cmd_valid <= 1'b1;
      @(posedge mclk_i);
      cmd_valid <= 1'b0;
      #1;
   endtask

   task ask(input step_motion_pkg::cmd_code_type c, input logic [15:0] exp);
      send(c, 1'b0, 16'h0000);
      check(16'(rv), 16'h0001, "reply strobe");
      check(rval, exp, "reply value");
   endtask

   task wait_idle;
      int n;
      for (n = 0; n < 200 && run !== 1'b0; n++) begin
         @(posedge mclk_i);
         #1;
      end
      if (run !== 1'b0) begin
         err_count++;
         summarize;
      end
   endtask

   initial begin
      repeat (16) @(posedge mclk_i);
      arst_n_i <= 1'b1;
      #1;
      check(16'(div), 16'h0004, "divider reset");
      ask(step_motion_pkg::CMD_JOG_SPEED, 16'h0190);
      ask(step_motion_pkg::CMD_DIVIDER, 16'h0004);
      ask(step_motion_pkg::CMD_HOLD, 16'h0064);
      $display("test reset done");
      send(step_motion_pkg::CMD_DIVIDER, 1'b1, 16'h0000);
      check(16'(div), 16'h0004, "divider zero");
      send(step_motion_pkg::CMD_DIVIDER, 1'b1, 16'h00ff);
      check(16'(div), 16'h00ff, "divider max");
      send(step_motion_pkg::CMD_HOLD, 1'b1, 16'h0004);
      ask(step_motion_pkg::CMD_HOLD, 16'h0064);
      send(step_motion_pkg::CMD_HOLD, 1'b1, 16'h0100);
      ask(step_motion_pkg::CMD_HOLD, 16'h0064);
      send(step_motion_pkg::CMD_HOLD, 1'b1, 16'h0005);
      ask(step_motion_pkg::CMD_HOLD, 16'h0005);
      send(step_motion_pkg::CMD_JOG_SPEED, 1'b1, 16'h0320);
      ask(step_motion_pkg::CMD_JOG_SPEED, 16'h0320);
      @(posedge mclk_i);
      imm <= 1'b0;
      send(step_motion_pkg::CMD_JOG_SPEED, 1'b0, 16'h0000);
      check(16'(rv), 16'h0000, "no reply outside immediate mode");
      @(posedge mclk_i);
      imm <= 1'b1;
      ask(step_motion_pkg::CMD_JOG_SPEED, 16'h0320);
      $display("test params done");
      for (int i = 0; i < 4; i++) begin
         send(step_motion_pkg::CMD_MEMORY, 1'b1, i[15:0]);
         check(16'({erase, ld_def, rst_prg, rst_par}), 16'h0001 << i, "memory op");
         check(16'(div), 16'(exp_div[i]), "memory divider");
      end
      send(step_motion_pkg::CMD_MEMORY, 1'b0, 16'h0000);
      check(16'({erase, ld_def, rst_prg, rst_par}), 16'h0001, "memory default");
      ask(step_motion_pkg::CMD_JOG_SPEED, 16'h03e8);
      send(step_motion_pkg::CMD_MEMORY, 1'b1, 16'h0002);
      send(step_motion_pkg::CMD_HOLD, 1'b1, 16'h0005);
      $display("test memory done");
      @(posedge mclk_i);
      jog_m <= 1'b1;
      @(posedge mclk_i);
      #1;
      check(16'({abort, halt, run, dir, ramp}), 16'h001f, "jog start");
      @(posedge mclk_i);
      #1;
      check(rate, 16'h0064, "jog rate");
      @(posedge mclk_i);
      jog_m <= 1'b0;
      wait_idle;
      check(16'(run_cur), 16'h0001, "run current after stop");
      repeat (30) @(posedge mclk_i);
      #1;
      check(16'(run_cur), 16'h0000, "hold current");
      $display("test jog done");
      @(posedge mclk_i);
      init_vel <= 16'h07d0;
      send(step_motion_pkg::CMD_HOME, 1'b1, 16'h0320);
      check(16'({run, ramp, dir, busy}), 16'h000d, "home seek");
      @(posedge mclk_i);
      #1;
      check(rate, 16'h00c8, "home rate");
      @(posedge mclk_i);
      sw_n <= 1'b0;
      @(posedge mclk_i);
      #1;
      check(16'(stop), 16'h0001, "home decel");
      for (int n = 0; n < 50 && stop !== 1'b0; n++) begin
         @(posedge mclk_i);
         #1;
      end
      if (stop !== 1'b0) begin
         err_count++;
         summarize;
      end
      check(16'({dir, ramp, stop}), 16'h0004, "home reverse");
      @(posedge mclk_i);
      #1;
      check(rate, 16'h01f4, "reverse rate");
      @(posedge mclk_i);
      sw_n <= 1'b1;
      @(posedge mclk_i);
      #1;
      check(16'({halt, run, busy}), 16'h0004, "home stop");
      $display("test home done");
      send(step_motion_pkg::CMD_HOLD, 1'b1, 16'h00ff);
      @(posedge mclk_i);
      jog_p <= 1'b1;
      repeat (10) @(posedge mclk_i);
      jog_p <= 1'b0;
      wait_idle;
      check(16'(dir), 16'h0000, "jog plus dir");
      repeat (1100) @(posedge mclk_i);
      #1;
      check(16'(run_cur), 16'h0001, "hold disabled");
      $display("test hold off done");
      summarize;
   end
endmodule
